// ===== core/rlc_lane_regs.sv
`timescale 1ns/100ps
// What this block does
// - Swing bit 7 enables output short protection.
// - Swing bit 6 set selects gen 1/2.
// - Swing bits 2:0 select level, default 101.
// - De-emphasis bit 7 reads receiver presence.
// - De-emphasis bits 6:5 read detected speed.
// - De-emphasis bits 2:0 select level, default 010.
// - Idle bits 3:2 set assert threshold.
// - Idle bits 1:0 set deassert threshold.
// - Bits 5/4 enable high signal-detect range.
// - Bits 3/2 enable fast signal detect.
// - Bits 1/0 enable reduced signal-detect gain.
// - Lane A0 bit 5 picks manual idle.
// - Manual bit 4 mutes lane output.
// - Bits 3:2 pick receiver-detect termination mode.
module rlc_lane_regs #(
    parameter int PROBE_PERIOD_CYC = rlc_pkg::PROBE_PERIOD_CYC,
    parameter int PROBE_MAX_TRIES = rlc_pkg::PROBE_MAX_TRIES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input rlc_pkg::rlc_req_s req, // Register write request
    input wire logic [7:0] rd_addr, // Register read address
    output logic [7:0] rd_data, // Read data, one cycle after rd_addr
    input wire logic rx_present, // Lane B3 far-end receiver found
    input wire logic [1:0] speed_detect_result, // Lane B3 detected speed
    input wire logic a0_auto_idle, // Lane A0 automatic idle verdict
    input wire logic a0_rx_seen, // Lane A0 probe answered
    output rlc_pkg::rlc_lane_ctl_s lane_b3_ctl, // Lane B3 analog controls
    output logic a0_mute, // Lane A0 output in electrical idle
    output logic a0_probe, // Lane A0 receiver-detect probe pulse
    output logic a0_term_50 // Lane A0 input terminated 50 ohm
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] swing_reg; // Swing control
    logic [7:0] deemph_reg; // De-emphasis, low writable bits only
    logic [7:0] idle_th_reg; // Idle thresholds
    logic [7:0] sd_ctl_reg; // Signal-detect control
    logic [7:0] rsvd_a_reg; // Reserved storage
    logic [7:0] rsvd_b_reg; // Reserved storage
    logic [7:0] a0_idle_reg; // Lane A0 idle / receiver detect
    logic [7:0] rd_next; // Read mux
    logic [7:0] deemph_view; // De-emphasis with live status

    // Merge a write into a register under the allowed bit mask
    function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wdat,
                                         input logic [7:0] wmask, input logic [7:0] emask,
                                         input logic from_mem);
        logic [7:0] m;
        m = from_mem ? (wmask & emask) : wmask;
        return (cur & ~m) | (wdat & m);
    endfunction

    // Write strobe for one offset
    function automatic logic hit(input rlc_pkg::rlc_req_s r, input logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    // ----------------------------------------------------------------
    // Lane B3 swing register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            swing_reg <= rlc_pkg::RST_SWING;
        end else if (hit(req, rlc_pkg::OFS_SWING)) begin
            // Reserved bits stored as written; software keeps 101
            swing_reg <= merge(swing_reg, req.data, rlc_pkg::WMASK_ALL,
                               rlc_pkg::EMASK_SWING, req.ee);
        end
    end

    // ----------------------------------------------------------------
    // Lane B3 de-emphasis register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            deemph_reg <= rlc_pkg::RST_DEEMPH;
        end else if (hit(req, rlc_pkg::OFS_DEEMPH)) begin
            // Status bits are never stored
            deemph_reg <= merge(deemph_reg, req.data, rlc_pkg::WMASK_DEEMPH,
                                rlc_pkg::EMASK_DEEMPH, req.ee);
        end
    end

    // ----------------------------------------------------------------
    // Lane B3 idle threshold register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_th_reg <= rlc_pkg::RST_IDLE_TH;
        end else if (hit(req, rlc_pkg::OFS_IDLE_TH)) begin
            idle_th_reg <= merge(idle_th_reg, req.data, rlc_pkg::WMASK_ALL,
                                 rlc_pkg::EMASK_IDLE_TH, req.ee);
        end
    end

    // ----------------------------------------------------------------
    // Shared signal-detect control register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sd_ctl_reg <= rlc_pkg::RST_SD_CTL;
        end else if (hit(req, rlc_pkg::OFS_SD_CTL)) begin
            sd_ctl_reg <= merge(sd_ctl_reg, req.data, rlc_pkg::WMASK_ALL,
                                rlc_pkg::EMASK_SD_CTL, req.ee);
        end
    end

    // ----------------------------------------------------------------
    // Reserved registers, plain storage
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsvd_a_reg <= rlc_pkg::RST_RSVD;
            rsvd_b_reg <= rlc_pkg::RST_RSVD;
        end else begin
            if (hit(req, rlc_pkg::OFS_RSVD_A)) begin
                rsvd_a_reg <= merge(rsvd_a_reg, req.data, rlc_pkg::WMASK_ALL,
                                    rlc_pkg::EMASK_RSVD, req.ee);
            end
            if (hit(req, rlc_pkg::OFS_RSVD_B)) begin
                rsvd_b_reg <= merge(rsvd_b_reg, req.data, rlc_pkg::WMASK_ALL,
                                    rlc_pkg::EMASK_RSVD, req.ee);
            end
        end
    end

    // ----------------------------------------------------------------
    // Lane A0 idle / receiver-detect register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            a0_idle_reg <= rlc_pkg::RST_A0_IDLE;
        end else if (hit(req, rlc_pkg::OFS_A0_IDLE)) begin
            a0_idle_reg <= merge(a0_idle_reg, req.data, rlc_pkg::WMASK_ALL,
                                 rlc_pkg::EMASK_A0_IDLE, req.ee);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Live status overlays the stored de-emphasis bits
    assign deemph_view = {rx_present, speed_detect_result, deemph_reg[4:0]};

    always_comb begin
        case (rd_addr)
            rlc_pkg::OFS_SWING: rd_next = swing_reg;
            rlc_pkg::OFS_DEEMPH: rd_next = deemph_view;
            rlc_pkg::OFS_IDLE_TH: rd_next = idle_th_reg;
            rlc_pkg::OFS_SD_CTL: rd_next = sd_ctl_reg;
            rlc_pkg::OFS_RSVD_A: rd_next = rsvd_a_reg;
            rlc_pkg::OFS_RSVD_B: rd_next = rsvd_b_reg;
            rlc_pkg::OFS_A0_IDLE: rd_next = a0_idle_reg;
            default: rd_next = 8'h00; // Unmapped offsets read zero
        endcase
    end

    // Registered read data
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_next;
        end
    end

    // ----------------------------------------------------------------
    // Lane controls
    // ----------------------------------------------------------------
    // Fields drive the lanes straight from the registers
    always_comb begin
        lane_b3_ctl.short_prot_en = swing_reg[rlc_pkg::BIT_SHORT_PROT];
        lane_b3_ctl.rate_gen12 = swing_reg[rlc_pkg::BIT_RATE_SEL];
        lane_b3_ctl.output_swing_level = swing_reg[rlc_pkg::LSB_LEVEL +: 3];
        lane_b3_ctl.output_deemphasis_level = deemph_reg[rlc_pkg::LSB_LEVEL +: 3];
        lane_b3_ctl.idle_assert_sel = idle_th_reg[rlc_pkg::LSB_IDLE_ASSERT +: 2];
        lane_b3_ctl.idle_deassert_sel = idle_th_reg[rlc_pkg::LSB_IDLE_DEASSERT +: 2];
        lane_b3_ctl.sd_high_range = sd_ctl_reg[rlc_pkg::BIT_SD_HIGH_LO -: 2];
        lane_b3_ctl.sd_fast = sd_ctl_reg[rlc_pkg::BIT_SD_FAST_LO -: 2];
        lane_b3_ctl.sd_low_gain = sd_ctl_reg[rlc_pkg::BIT_SD_GAIN_LO -: 2];
    end

    // Manual mute only when manual idle is selected
    assign a0_mute = a0_idle_reg[rlc_pkg::BIT_IDLE_MANUAL]
                     ? a0_idle_reg[rlc_pkg::BIT_IDLE_MUTE]
                     : a0_auto_idle;

    // Lane A0 receiver-detect sequencer
    rlc_rx_probe #(
        .PERIOD_CYC(PROBE_PERIOD_CYC),
        .MAX_TRIES(PROBE_MAX_TRIES)
    ) u_probe (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .mode(a0_idle_reg[rlc_pkg::LSB_RX_SENSE_MODE +: 2]),
        .rx_seen(a0_rx_seen),
        .probe(a0_probe),
        .term_50(a0_term_50)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_short_prot;
        @(posedge ref_clk) disable iff (sys_rst)
        (hit(req, rlc_pkg::OFS_SWING) && !req.ee) |=> lane_b3_ctl.short_prot_en == $past(req.data[7]);
    endproperty
    a_short_prot: assert property (p_short_prot) else $error("short protect not updated");

    property p_rate_sel;
        @(posedge ref_clk) disable iff (sys_rst)
        (hit(req, rlc_pkg::OFS_SWING) && !req.ee) |=> lane_b3_ctl.rate_gen12 == $past(req.data[6]);
    endproperty
    a_rate_sel: assert property (p_rate_sel) else $error("rate select not updated");

    property p_swing_level;
        @(posedge ref_clk) disable iff (sys_rst)
        hit(req, rlc_pkg::OFS_SWING) |=> lane_b3_ctl.output_swing_level == $past(req.data[2:0]);
    endproperty
    a_swing_level: assert property (p_swing_level) else $error("swing level wrong");

    property p_status_read;
        @(posedge ref_clk) disable iff (sys_rst)
        (rd_addr == rlc_pkg::OFS_DEEMPH) |=> rd_data[7:5] == $past({rx_present, speed_detect_result});
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bits wrong");

    property p_deemph_level;
        @(posedge ref_clk) disable iff (sys_rst)
        hit(req, rlc_pkg::OFS_DEEMPH) |=> lane_b3_ctl.output_deemphasis_level == $past(req.data[2:0]);
    endproperty
    a_deemph_level: assert property (p_deemph_level) else $error("de-emphasis wrong");

    property p_idle_thresh;
        @(posedge ref_clk) disable iff (sys_rst)
        hit(req, rlc_pkg::OFS_IDLE_TH)
            |=> {lane_b3_ctl.idle_assert_sel, lane_b3_ctl.idle_deassert_sel} == $past(req.data[3:0]);
    endproperty
    a_idle_thresh: assert property (p_idle_thresh) else $error("idle threshold wrong");

    property p_sd_ctl;
        @(posedge ref_clk) disable iff (sys_rst)
        hit(req, rlc_pkg::OFS_SD_CTL) |=> {lane_b3_ctl.sd_high_range, lane_b3_ctl.sd_fast,
                                           lane_b3_ctl.sd_low_gain} == $past(req.data[5:0]);
    endproperty
    a_sd_ctl: assert property (p_sd_ctl) else $error("signal detect ctl wrong");

    property p_mute_sel;
        @(posedge ref_clk) disable iff (sys_rst)
        (hit(req, rlc_pkg::OFS_A0_IDLE) && !req.ee && req.data[5])
            |=> a0_mute == $past(req.data[4]);
    endproperty
    a_mute_sel: assert property (p_mute_sel) else $error("manual mute ignored");

    property p_reset_vals;
        @(posedge ref_clk) $fell(sys_rst)
            |-> swing_reg == rlc_pkg::RST_SWING && sd_ctl_reg == rlc_pkg::RST_SD_CTL;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

endmodule // rlc_lane_regs

// ===== core/rlc_pkg.sv
package rlc_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_SWING = 8'h25; // Lane B3 swing control
    localparam logic [7:0] OFS_DEEMPH = 8'h26; // Lane B3 de-emphasis and status
    localparam logic [7:0] OFS_IDLE_TH = 8'h27; // Lane B3 idle thresholds
    localparam logic [7:0] OFS_SD_CTL = 8'h28; // Shared signal-detect control
    localparam logic [7:0] OFS_RSVD_A = 8'h29; // Reserved, read/write
    localparam logic [7:0] OFS_RSVD_B = 8'h2a; // Reserved, read/write
    localparam logic [7:0] OFS_A0_IDLE = 8'h2b; // Lane A0 idle and receiver detect

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_SWING = 8'had;
    localparam logic [7:0] RST_DEEMPH = 8'h02;
    localparam logic [7:0] RST_IDLE_TH = 8'h00;
    localparam logic [7:0] RST_SD_CTL = 8'h0c;
    localparam logic [7:0] RST_RSVD = 8'h00;
    localparam logic [7:0] RST_A0_IDLE = 8'h00;

    // ----------------------------------------------------------------
    // Writable bits, and the bits the configuration memory may load
    // ----------------------------------------------------------------
    localparam logic [7:0] WMASK_ALL = 8'hff;
    localparam logic [7:0] WMASK_DEEMPH = 8'h1f; // Bits 7:5 are status
    localparam logic [7:0] EMASK_SWING = 8'hff;
    localparam logic [7:0] EMASK_DEEMPH = 8'h07;
    localparam logic [7:0] EMASK_IDLE_TH = 8'h8f;
    localparam logic [7:0] EMASK_SD_CTL = 8'h7f;
    localparam logic [7:0] EMASK_RSVD = 8'h00;
    localparam logic [7:0] EMASK_A0_IDLE = 8'h3c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_SHORT_PROT = 7;
    localparam int BIT_RATE_SEL = 6;
    localparam int BIT_RX_PRESENT = 7;
    localparam int LSB_SPEED = 5;
    localparam int LSB_LEVEL = 0; // Swing, de-emphasis fields [2:0]
    localparam int LSB_IDLE_ASSERT = 2;
    localparam int LSB_IDLE_DEASSERT = 0;
    localparam int BIT_SD_HIGH_LO = 5; // Lanes 0-3, lanes 4-7 one below
    localparam int BIT_SD_FAST_LO = 3;
    localparam int BIT_SD_GAIN_LO = 1;
    localparam int BIT_IDLE_MANUAL = 5;
    localparam int BIT_IDLE_MUTE = 4;
    localparam int LSB_RX_SENSE_MODE = 2;

    // ----------------------------------------------------------------
    // Receiver-detect timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int PROBE_PERIOD_MS = 12;
    localparam int PROBE_PERIOD_CYC = PROBE_PERIOD_MS * CLK_MHZ * 1000;
    localparam int PROBE_MAX_TRIES = 50;

    // Receiver-detect modes
    localparam logic [1:0] RX_SENSE_HIZ = 2'h0;
    localparam logic [1:0] RX_SENSE_LIMITED = 2'h1;
    localparam logic [1:0] RX_SENSE_ENDLESS = 2'h2;
    localparam logic [1:0] RX_SENSE_TERM50 = 2'h3;

    // Register access request (management bus or configuration load)
    typedef struct packed {
        logic wr; // One-cycle write strobe
        logic ee; // Write comes from configuration memory
        logic [7:0] addr;
        logic [7:0] data;
    } rlc_req_s;

    // Control fields presented to the analog lanes
    typedef struct packed {
        logic short_prot_en;
        logic rate_gen12;
        logic [2:0] output_swing_level;
        logic [2:0] output_deemphasis_level;
        logic [1:0] idle_assert_sel;
        logic [1:0] idle_deassert_sel;
        logic [1:0] sd_high_range; // [1] lanes 0-3, [0] lanes 4-7
        logic [1:0] sd_fast;
        logic [1:0] sd_low_gain;
    } rlc_lane_ctl_s;

endpackage

// ===== core/rlc_rx_probe.sv
`timescale 1ns/100ps
module rlc_rx_probe #(
    parameter int PERIOD_CYC = rlc_pkg::PROBE_PERIOD_CYC,
    parameter int MAX_TRIES = rlc_pkg::PROBE_MAX_TRIES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [1:0] mode, // Receiver-detect mode field
    input wire logic rx_seen, // Far end answered the current probe
    output logic probe, // One-cycle probe pulse
    output logic term_50 // Input termination 50 ohm when high
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {ST_HIZ, ST_SEARCH, ST_FOUND, ST_GAVE_UP, ST_FIXED} rlc_probe_e;

    localparam int TW = $clog2(PERIOD_CYC + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(PERIOD_CYC - 1);
    localparam logic [6:0] TRIES_MAX = 7'(MAX_TRIES);

    rlc_probe_e state_reg; // Detection state
    logic [1:0] mode_reg; // Mode seen last cycle
    logic [TW-1:0] timer_reg; // Probe interval
    logic [6:0] tries_reg; // Probes sent in this search
    logic fire; // Interval elapsed while searching

    assign fire = (state_reg == ST_SEARCH) && (timer_reg == TIMER_LAST);
    assign probe = fire;
    assign term_50 = (state_reg == ST_FOUND) || (state_reg == ST_FIXED);

    // ----------------------------------------------------------------
    // Mode tracking and state machine
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= 2'h0;
            state_reg <= ST_HIZ;
        end else begin
            mode_reg <= mode;
            if (mode != mode_reg) begin
                // A change to mode 01 or 10 restarts the search; 00 and 11 go to fixed states
                case (mode)
                    rlc_pkg::RX_SENSE_TERM50: state_reg <= ST_FIXED;
                    rlc_pkg::RX_SENSE_HIZ: state_reg <= ST_HIZ;
                    default: state_reg <= ST_SEARCH;
                endcase
            end else begin
                case (state_reg)
                    ST_SEARCH: begin
                        if (fire && rx_seen) begin
                            state_reg <= ST_FOUND;
                        end else if (fire && mode == rlc_pkg::RX_SENSE_LIMITED
                                     && tries_reg == TRIES_MAX - 7'h01) begin
                            state_reg <= ST_GAVE_UP;
                        end
                    end
                    default: state_reg <= state_reg;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Interval timer and probe count
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_reg <= '0;
            tries_reg <= 7'h00;
        end else if (mode != mode_reg || state_reg != ST_SEARCH) begin
            timer_reg <= '0;
            tries_reg <= 7'h00;
        end else if (fire) begin
            timer_reg <= '0;
            tries_reg <= (tries_reg == 7'h7f) ? tries_reg : tries_reg + 7'h01;
        end else begin
            timer_reg <= timer_reg + TW'(1);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_limit_tries;
        @(posedge ref_clk) disable iff (sys_rst)
        // Skip the change cycle: an endless search may leave a high count
        (mode == rlc_pkg::RX_SENSE_LIMITED && mode == mode_reg) |-> (tries_reg <= TRIES_MAX);
    endproperty
    a_limit_tries: assert property (p_limit_tries) else $error("too many probes");

    property p_fixed_term;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode == rlc_pkg::RX_SENSE_TERM50) [*2] |-> term_50 && !probe;
    endproperty
    a_fixed_term: assert property (p_fixed_term) else $error("mode 11 not 50 ohm");

    property p_found_term;
        @(posedge ref_clk) disable iff (sys_rst)
        (probe && rx_seen && mode == $past(mode) && mode == mode_reg)
            ##1 (mode == mode_reg) |-> term_50;
    endproperty
    a_found_term: assert property (p_found_term) else $error("detect not terminated");

endmodule // rlc_rx_probe

// ===== sim/rlc_far_end.sv
`timescale 1ns/100ps
// Far end of lane A0: a receiver that answers probes when fitted
module rlc_far_end (
    input wire logic a0_probe,
    input wire logic fitted,
    output logic a0_rx_seen
);
    // Answer only inside the probe cycle, quiet otherwise
    assign a0_rx_seen = a0_probe & fitted;
endmodule // rlc_far_end

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic ref_clk = 1'b0; // 250 MHz clock
    logic sys_rst = 1'b1; // Reset, high at start
    rlc_pkg::rlc_req_s req = '0; // Write port
    logic [7:0] rd_addr = 8'h00; // Read address
    logic [7:0] rd_data; // Read data
    logic rx_present = 1'b0; // Lane B3 receiver found
    logic [1:0] speed_detect_result = 2'h0; // Lane B3 speed
    logic a0_auto_idle = 1'b0; // Lane A0 idle verdict
    logic a0_rx_seen, a0_mute, a0_probe, a0_term_50; // Lane A0 lines
    logic fitted = 1'b0; // Far-end receiver fitted
    rlc_pkg::rlc_lane_ctl_s lane_b3_ctl; // Lane B3 controls
    logic [7:0] rst_tab [7] = '{8'had, 8'h02, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h00}; // Defaults
    int fail_count = 0; // Mismatches
    int cmp_count = 0; // Comparisons
    int probe_cnt = 0; // Probe pulses seen
    int n; // Wait counter
    // Clock and probe counter
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (a0_probe === 1'b1) probe_cnt++;
    end
    // ----------------------------------------------------------------
    // Design and far end
    // ----------------------------------------------------------------
    rlc_lane_regs #(.PROBE_PERIOD_CYC(20), .PROBE_MAX_TRIES(4)) dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rd_addr(rd_addr),
        .rd_data(rd_data), .rx_present(rx_present),
        .speed_detect_result(speed_detect_result), .a0_auto_idle(a0_auto_idle),
        .a0_rx_seen(a0_rx_seen), .lane_b3_ctl(lane_b3_ctl), .a0_mute(a0_mute),
        .a0_probe(a0_probe), .a0_term_50(a0_term_50));
    rlc_far_end far_u (.a0_probe(a0_probe), .fitted(fitted), .a0_rx_seen(a0_rx_seen));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ee = 1'b0);
        @(posedge ref_clk);
        #1 req = '{wr: 1'b1, ee: ee, addr: a, data: d};
        @(posedge ref_clk);
        #1 req.wr = 1'b0;
    endtask
    // Read answers one cycle after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        #1 rd_addr = a;
        @(posedge ref_clk);
        #1 chk(rd_data, exp);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #40000;
        fail_count++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        // Defaults, then a hole in the map
        foreach (rst_tab[i]) rd(8'(8'h25 + i), rst_tab[i]);
        rd(8'h30, 8'h00);
        // Swing writes keep bits 5:3 at 101
        wr(8'h25, 8'h2f);
        chk({lane_b3_ctl.short_prot_en, lane_b3_ctl.rate_gen12, 3'h0, lane_b3_ctl.output_swing_level}, 8'h07);
        wr(8'h25, 8'he8);
        chk({lane_b3_ctl.short_prot_en, lane_b3_ctl.rate_gen12, 3'h0, lane_b3_ctl.output_swing_level}, 8'hc0);
        // Status bits are live, not writable
        rx_present = 1'b1;
        speed_detect_result = 2'h3;
        wr(8'h26, 8'hff);
        chk({5'h0, lane_b3_ctl.output_deemphasis_level}, 8'h07);
        rd(8'h26, 8'hff);
        rx_present = 1'b0;
        speed_detect_result = 2'h1;
        rd(8'h26, 8'h3f);
        // Idle thresholds, then a memory load
        wr(8'h27, 8'h0e);
        chk({4'h0, lane_b3_ctl.idle_assert_sel, lane_b3_ctl.idle_deassert_sel}, 8'h0e);
        wr(8'h27, 8'hff, 1'b1);
        rd(8'h27, 8'h8f);
        // Signal-detect groups
        wr(8'h28, 8'h2a);
        chk({2'h0, lane_b3_ctl.sd_high_range, lane_b3_ctl.sd_fast, lane_b3_ctl.sd_low_gain}, 8'h2a);
        // Automatic against manual idle
        a0_auto_idle = 1'b1;
        wr(8'h2b, 8'h00);
        chk({7'h0, a0_mute}, 8'h01);
        a0_auto_idle = 1'b0;
        wr(8'h2b, 8'h30);
        chk({7'h0, a0_mute}, 8'h01);
        wr(8'h2b, 8'h20);
        chk({7'h0, a0_mute}, 8'h00);
        // Fixed termination modes
        wr(8'h2b, 8'h0c);
        repeat (2) @(posedge ref_clk);
        #1 chk({7'h0, a0_term_50}, 8'h01);
        wr(8'h2b, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1 chk({7'h0, a0_term_50}, 8'h00);
        // Limited search with nobody there stops after four probes
        probe_cnt = 0;
        wr(8'h2b, 8'h04);
        repeat (150) @(posedge ref_clk);
        #1 chk(probe_cnt[7:0], 8'h04);
        chk({7'h0, a0_term_50}, 8'h00);
        // Endless search finds a fitted receiver
        wr(8'h2b, 8'h00);
        fitted = 1'b1;
        probe_cnt = 0;
        wr(8'h2b, 8'h08);
        n = 0;
        while (a0_term_50 !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        #1 chk({7'h0, a0_term_50}, 8'h01);
        // Once found, probing stops and termination stays
        repeat (50) @(posedge ref_clk);
        #1 chk(probe_cnt[7:0], 8'h01);
        chk({7'h0, a0_term_50}, 8'h01);
        print_verdict();
    end
endmodule // testbench
